// ==== src/memory_board.sv ====
// memory board: program store, scratch store and configuration store
module memory_board (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [3:0] readback_block_switches,
   output logic read_busy,
   membus_if.board bus
);
   // ----------------------------------------------------------------
   // bus buffers
   // ----------------------------------------------------------------
   logic [7:0] addr_lo;
   logic [7:0] addr_hi;
   logic [7:0] wr_byte;
   logic addr_lo_oe;
   logic addr_hi_oe;
   logic wr_byte_oe;
   logic wr_buf_en_n;
   logic rd_buf_en_n;
   logic [7:0] rd_q;

   // address groups stay enabled: decode must see every cycle
   bus_buffer #(.W(8)) low_address_buffer (
      .a(bus.addr[7:0]),
      .en_n(membus_pkg::BUF_ON_N),
      .y(addr_lo),
      .oe(addr_lo_oe)
   );
   bus_buffer #(.W(8)) high_address_buffer (
      .a(bus.addr[15:8]),
      .en_n(membus_pkg::BUF_ON_N),
      .y(addr_hi),
      .oe(addr_hi_oe)
   );

   // write data only reaches the stores during a qualified write
   bus_buffer #(.W(8)) write_data_buffer (
      .a(bus.dout),
      .en_n(wr_buf_en_n),
      .y(wr_byte),
      .oe(wr_byte_oe)
   );

   // read driver feeds the shared data-in lanes
   bus_buffer #(.W(8)) read_data_buffer (
      .a(rd_q),
      .en_n(rd_buf_en_n),
      .y(bus.processor_input_lanes),
      .oe(bus.processor_input_lanes_oe)
   );

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [10:0] ofs;
   logic [4:0] slot;
   logic [31:0] chip_sel_n;
   logic addr_ok;
   logic rom_sel;
   logic blocked;
   logic scratch_store_chip;
   logic config_store_chip;
   logic [4:0] blk_idx;

   // buffered lines equal bus lines while enabled (non-inverting)
   assign addr_ok = addr_lo_oe & addr_hi_oe;
   assign ofs = {addr_hi[2:0], addr_lo};
   assign slot = addr_hi[7:3];

   // one active-low select per 2 KiB device slot
   always_comb begin
      chip_sel_n = '1;
      if (addr_ok) begin
         chip_sel_n[slot] = 1'b0;
      end
   end

   assign rom_sel = (slot - membus_pkg::SLOT_ROM_BASE)
      < 5'(membus_pkg::ROM_COUNT);
   assign scratch_store_chip = ~chip_sel_n[membus_pkg::SLOT_SCRATCH];
   assign config_store_chip = ~chip_sel_n[membus_pkg::SLOT_CONFIG];
   assign blk_idx = slot - membus_pkg::SLOT_BLOCK_BASE;

   // a closed switch hands this slot to another board on reads
   always_comb begin
      blocked = 1'b0;
      if (blk_idx < 5'(membus_pkg::BLOCKABLE_ROMS)) begin
         blocked = readback_block_switches[blk_idx[1:0]];
      end
   end

   // ----------------------------------------------------------------
   // strobe qualification
   // ----------------------------------------------------------------
   logic board_sel;
   logic rd_go;
   logic wr_go;

   // the board answers only inside its own map, never otherwise
   assign board_sel = addr_ok
      & (rom_sel | scratch_store_chip | config_store_chip);

   // read needs both strobes and an unblocked slot
   assign rd_go = bus.pdbin & bus.smemr & board_sel & ~blocked;
   assign rd_buf_en_n = ~rd_go;
   assign read_busy = rd_go;

   // program slots never open the write path
   assign wr_go = bus.mwrite
      & (scratch_store_chip | config_store_chip);
   assign wr_buf_en_n = ~wr_go;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] scratch_mem [membus_pkg::STORE_BYTES];
   logic [7:0] config_mem [membus_pkg::STORE_BYTES];

   // fixed program content; a constant so no write can reach it
   function automatic logic [7:0] rom_byte(
      input logic [4:0] dev,
      input logic [10:0] at
   );
      logic [7:0] v;
      v = at[7:0] ^ {dev, at[10:8]};
      return v;
   endfunction : rom_byte

   // scratch writes; contents are undefined after power-up
   always_ff @(posedge ref_clk) begin
      if (ce && wr_byte_oe && scratch_store_chip) begin
         scratch_mem[ofs] <= wr_byte;
      end
   end

   // config store has no reset so contents survive any reset
   always_ff @(posedge ref_clk) begin
      if (ce && wr_byte_oe && config_store_chip) begin
         config_mem[ofs] <= wr_byte;
      end
   end

   // ----------------------------------------------------------------
   // read data register
   // ----------------------------------------------------------------
   // fetched one cycle into the strobe; the held address makes
   // the byte settle before the processor samples it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_q <= membus_pkg::RD_RESET;
      end else if (ce && rd_go) begin
         if (scratch_store_chip) begin
            rd_q <= scratch_mem[ofs];
         end else if (config_store_chip) begin
            rd_q <= config_mem[ofs];
         end else begin
            rd_q <= rom_byte(slot, ofs);
         end
      end
   end
endmodule : memory_board

// ==== common/membus_pkg.sv ====
// shared constants for the memory board and its bus master
package membus_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int OFS_W = 11;
   localparam int SLOT_W = 5;
   localparam int ROM_COUNT = 8;
   localparam int BLOCKABLE_ROMS = 4;
   localparam logic [4:0] SLOT_ROM_BASE = 5'h00;
   localparam logic [4:0] SLOT_BLOCK_BASE = 5'h04;
   localparam logic [4:0] SLOT_SCRATCH = 5'h1E;
   localparam logic [4:0] SLOT_CONFIG = 5'h1F;
   localparam int STORE_BYTES = 2048;
   localparam logic BUF_ON_N = 1'b0;
   localparam logic [7:0] RD_RESET = 8'h00;
   localparam logic [7:0] FLOAT_BYTE = 8'hFF;
   localparam logic [1:0] STROBE_CYCLES = 2'h3;
   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_STROBE = 3'b010,
      M_FINISH = 3'b100
   } master_state_e;
endpackage : membus_pkg

// ==== common/membus_if.sv ====
// parallel system bus between processor and memory board
interface membus_if;
   logic [15:0] addr;
   logic [7:0] dout;
   logic pdbin;
   logic smemr;
   logic mwrite;
   logic [7:0] processor_input_lanes;
   logic processor_input_lanes_oe;
   modport proc (
      output addr,
      output dout,
      output pdbin,
      output smemr,
      output mwrite,
      input processor_input_lanes,
      input processor_input_lanes_oe
   );
   modport board (
      input addr,
      input dout,
      input pdbin,
      input smemr,
      input mwrite,
      output processor_input_lanes,
      output processor_input_lanes_oe
   );
endinterface : membus_if

// ==== src/bus_buffer.sv ====
// non-inverting buffer group with an active-low enable
module bus_buffer #(
   parameter int W = 8
) (
   input wire logic [W-1:0] a,
   input wire logic en_n,
   output logic [W-1:0] y,
   output logic oe
);
   // a disabled group passes nothing; oe stands in for high impedance
   assign oe = ~en_n;
   assign y = en_n ? '0 : a;
endmodule : bus_buffer

// ==== src/bus_master.sv ====
// processor end: runs one strobed read or write per request
module bus_master (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   membus_if.proc bus
);
   membus_pkg::master_state_e state_q;
   logic [1:0] cnt_q;
   logic wr_q;
   logic [15:0] addr_q;
   logic [7:0] dout_q;
   logic strobe_on;

   assign req_ready = (state_q == membus_pkg::M_IDLE);
   assign strobe_on = (state_q == membus_pkg::M_STROBE);

   // address and data held for the whole strobe window
   assign bus.addr = addr_q;
   assign bus.dout = dout_q;
   assign bus.pdbin = strobe_on & ~wr_q;
   assign bus.smemr = strobe_on & ~wr_q;
   assign bus.mwrite = strobe_on & wr_q;

   // sequence: idle, strobe for a fixed count, one finishing cycle
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= membus_pkg::M_IDLE;
         cnt_q <= '0;
      end else if (ce) begin
         unique case (state_q)
            membus_pkg::M_IDLE: begin
               if (req_valid) begin
                  state_q <= membus_pkg::M_STROBE;
                  cnt_q <= '0;
               end
            end
            membus_pkg::M_STROBE: begin
               cnt_q <= cnt_q + 2'h1;
               if (cnt_q == membus_pkg::STROBE_CYCLES - 2'h1) begin
                  state_q <= membus_pkg::M_FINISH;
               end
            end
            membus_pkg::M_FINISH: begin
               state_q <= membus_pkg::M_IDLE;
            end
            default: begin
               state_q <= membus_pkg::M_IDLE;
            end
         endcase
      end
   end

   // request latch
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= 1'b0;
         addr_q <= 16'h0000;
         dout_q <= 8'h00;
      end else if (ce && req_ready && req_valid) begin
         wr_q <= req_write;
         addr_q <= req_addr;
         dout_q <= req_wdata;
      end
   end

   // sample data-in on the last strobe cycle; an undriven bus reads
   // as all ones, as the pulled-up lanes would
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
      end else if (ce) begin
         rsp_valid <= strobe_on
            && cnt_q == membus_pkg::STROBE_CYCLES - 2'h1;
         if (strobe_on && !wr_q
             && cnt_q == membus_pkg::STROBE_CYCLES - 2'h1) begin
            rsp_rdata <= bus.processor_input_lanes_oe
               ? bus.processor_input_lanes
               : membus_pkg::FLOAT_BYTE;
         end
      end
   end
endmodule : bus_master

// ==== tb/membus_properties.sv ====
// timing and data checks on the processor-to-board bus
module membus_properties (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [15:0] addr,
   input wire logic [7:0] dout,
   input wire logic pdbin,
   input wire logic smemr,
   input wire logic mwrite,
   input wire logic [7:0] processor_input_lanes,
   input wire logic processor_input_lanes_oe
);
   // ----------------------------------------
   // bus checks
   // ----------------------------------------
   logic [4:0] slot;
   logic [7:0] rom_val;
   logic oe;
   logic [7:0] ln;
   // program bytes are a fixed pattern of slot and offset
   assign slot = addr[15:11];
   assign rom_val = addr[7:0] ^ {slot, addr[10:8]};
   assign oe = processor_input_lanes_oe;
   assign ln = processor_input_lanes;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence read_strobe;
      (pdbin && smemr) [*3] ##1 !pdbin;
   endsequence
   sequence write_strobe;
      mwrite [*3] ##1 !mwrite;
   endsequence
   read_len_a: assert property ($rose(pdbin) |-> read_strobe)
      else $error("read strobe length wrong");
   write_len_a: assert property ($rose(mwrite) |-> write_strobe)
      else $error("write strobe length wrong");
   addr_hold_a: assert property (($past(pdbin) || $past(mwrite))
      && (pdbin || mwrite) |-> $stable(addr))
      else $error("address moved under strobe");
   dout_hold_a: assert property (mwrite && $past(mwrite)
      |-> $stable(dout)) else $error("write data moved");
   no_mix_a: assert property (!(mwrite && pdbin))
      else $error("read and write strobes together");
   drive_needs_read_a: assert property (oe |-> pdbin && smemr)
      else $error("board drives without read");
   unmapped_quiet_a: assert property (slot > 5'h07 && slot < 5'h1E
      |-> !oe) else $error("unmapped slot driven");
   float_zero_a: assert property (!oe |-> ln == 8'h00)
      else $error("lanes not parked");
   rom_data_a: assert property (oe && $past(oe) && slot < 5'h08
      |-> ln == rom_val) else $error("program byte wrong");
   oe_follows_a: assert property ($rose(pdbin) && slot < 5'h04
      |-> oe) else $error("board silent on read");
endmodule : membus_properties

// ==== tb/system_bus_memory_board_tb.sv ====
// bench: processor end driving the memory board
module system_bus_memory_board_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // stimulus and monitor
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] readback_block_switches = 4'h0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_wdata = 8'h00;
   logic req_ready;
   logic rsp_valid;
   logic [7:0] rsp_rdata;
   logic [9:0] exq[$];
   logic [9:0] e;
   logic read_busy;
   logic busy_seen = 1'b0;
   logic [7:0] mem[logic [15:0]];
   logic [15:0] wa[8];
   int n_errors = 0;
   int tests_run = 0;
   int seed = 31;
   membus_if bus ();
   memory_board i_memory_board (.ref_clk(ref_clk), .arst_n(arst_n),
      .ce(1'b1), .readback_block_switches(readback_block_switches),
      .read_busy(read_busy), .bus(bus));
   bus_master i_bus_master (.ref_clk(ref_clk), .arst_n(arst_n),
      .ce(1'b1), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus(bus));
   membus_properties i_membus_properties (.ref_clk(ref_clk),
      .arst_n(arst_n), .addr(bus.addr), .dout(bus.dout),
      .pdbin(bus.pdbin), .smemr(bus.smemr), .mwrite(bus.mwrite),
      .processor_input_lanes(bus.processor_input_lanes),
      .processor_input_lanes_oe(bus.processor_input_lanes_oe));
   always #25 ref_clk = ~ref_clk;
   // blocked or unmapped reads float, so the master sees all ones
   function automatic logic [7:0] exp_rd(input logic [15:0] a);
      logic [4:0] s;
      s = a[15:11];
      if (s < 5'h08 && !(s > 5'h03 && readback_block_switches[s[1:0]]))
         return a[7:0] ^ {s, a[10:8]};
      if (s > 5'h1D && mem.exists(a))
         return mem[a];
      return membus_pkg::FLOAT_BYTE;
   endfunction : exp_rd
   // board drives only for mapped, unblocked reads
   function automatic logic exp_on(input logic [15:0] a);
      logic [4:0] s;
      s = a[15:11];
      if (s > 5'h1D)
         return 1'b1;
      return s < 5'h08 && !(s > 5'h03 && readback_block_switches[s[1:0]]);
   endfunction : exp_on
   // one request; valid drops half a cycle after it is taken
   task automatic op(input logic w, input logic [15:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      @(negedge ref_clk);
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      // a master that never gets ready is a failure, not a skip
      if (n >= 20) begin
         n_errors++;
         $display("mismatch at %0t: %h vs %h", $time, req_ready, 1'b1);
      end
      exq.push_back({exp_on(a) && !w, !w, w ? 8'h00 : exp_rd(a)});
      if (w && a[15:12] == 4'hF)
         mem[a] = d;
      @(negedge ref_clk);
      req_valid = 1'b0;
   endtask : op
   task automatic complete_run();
      $display("counts: %0d compares, %0d mismatches", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // responses come back in request order
   always @(negedge ref_clk) begin
      if (read_busy === 1'b1)
         busy_seen = 1'b1;
      if (rsp_valid === 1'b1 && exq.size() > 0) begin
         e = exq.pop_front();
         tests_run++;
         if (busy_seen !== e[9]) begin
            n_errors++;
            $display("mismatch at %0t: %h vs %h", $time, busy_seen, e[9]);
         end
         busy_seen = 1'b0;
         if (e[8]) begin
            tests_run++;
            if (rsp_rdata !== e[7:0]) begin
               n_errors++;
               $display("mismatch at %0t: %h vs %h", $time, rsp_rdata,
                  e[7:0]);
            end
         end
      end
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b1;
      for (int i = 0; i < 8; i++)
         wa[i] = {4'hF, i[0], i < 4 ? {11{i[1]}} : 11'($random(seed))};
      for (int k = 0; k < 2; k++)
         foreach (wa[i]) op(1'b1, wa[i], 8'($random(seed)));
      foreach (wa[i]) op(1'b0, wa[i], 8'h00);
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      arst_n = 1'b1;
      foreach (wa[i]) if (wa[i][11]) op(1'b0, wa[i], 8'h00);
      $display("test writable stores done");
      for (int s = 0; s < 8; s++) begin
         wa[0] = {5'(s), 11'($random(seed))};
         op(1'b1, wa[0], 8'($random(seed)));
         op(1'b0, wa[0], 8'h00);
      end
      $display("test program store done");
      for (int i = 0; i < 4; i++) begin
         // switches are static: let the last read finish first
         repeat (4) @(negedge ref_clk);
         readback_block_switches = 4'h1 << i;
         for (int s = 4; s < 8; s++)
            op(1'b0, {5'(s), 11'($random(seed))}, 8'h00);
      end
      repeat (4) @(negedge ref_clk);
      readback_block_switches = 4'h0;
      $display("test read blocking done");
      for (int s = 8; s < 30; s += 7)
         op(1'b0, {5'(s), 11'($random(seed))}, 8'h00);
      $display("test unmapped reads done");
      repeat (8) @(negedge ref_clk);
      // an answer that never came leaves a note behind
      if (exq.size() != 0) begin
         n_errors++;
         $display("mismatch at %0t: %h vs %h", $time, exq.size(), 0);
      end
      complete_run();
   end
   // hang guard sized well above the expected run length
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      complete_run();
   end
endmodule : system_bus_memory_board_tb
